//--- rtl/boot_ser_if.sv
`timescale 1ns/1ps
interface boot_ser_if;
  logic        enable;
  logic [31:0] word;
  logic        valid;

  modport rx
  (
    input  enable,
    output word,
    output valid
  );

  modport core
  (
    output enable,
    input  word,
    input  valid
  );
endinterface : boot_ser_if

//--- rtl/dsp_boot_loader.sv
`timescale 1ns/1ps
`include "dsp_boot_loader_map.svh"
// Function
// - loader only when strap high on the first clock edge after reset release
// - sample four active-low interrupt pins for source
// - pins map to three regions and serial
// - header word 0 gives width 8/16/32
// - header word 1 sets later access timing
// - word 2 length, word 3 destination
// - assemble full 32-bit words from narrow reads
// - copy exactly length words to consecutive addresses
// - code words use same ordering as header
// - further blocks carry own length and destination
// - zero length after block ends loading
// - execution starts at first block destination
// - serial port locked to 32-bit frame-synced bursts
// - serial header holds only length and destination
// - loader-mode vectors point into final 63 RAM words
// - fixed branch slot layout per source
module dsp_boot_loader
  import dsp_boot_loader_pkg::*;
(
  // clock and reset
  input  wire logic                      i_core_clk,
  input  wire logic                      i_rst_b,
  // strap and source select pins
  input  wire logic                      i_boot_mode_strap_pin,
  input  wire logic                      i_ext_irq_pin_0_b,
  input  wire logic                      i_ext_irq_pin_1_b,
  input  wire logic                      i_ext_irq_pin_2_b,
  input  wire logic                      i_ext_irq_pin_3_b,
  // boot memory read port
  output logic                           o_mem_rd_req,
  output logic [23:0]                    o_mem_addr,
  input  wire logic [31:0]               i_mem_rd_data,
  input  wire logic                      i_mem_rd_ack,
  output logic [31:0]                    o_bus_ctrl,
  // destination write port
  output logic                           o_wr_req,
  output logic [23:0]                    o_wr_addr,
  output logic [31:0]                    o_wr_data,
  input  wire logic                      i_wr_ack,
  // serial port 0 pins
  input  wire logic                      i_ser_bit_clk,
  input  wire logic                      i_receive_frame_sync,
  input  wire logic                      i_ser_data,
  output logic                           o_ser_fixed32_lock,
  // vector lookup
  input  wire dsp_boot_loader_pkg::vec_src_t i_vec_src,
  input  wire logic [4:0]                i_vec_trap_num,
  output logic [23:0]                    o_vec_addr,
  // status
  output logic                           o_boot_loader_mode,
  output logic                           o_exec_start,
  output logic [23:0]                    o_exec_addr,
  output logic                           o_boot_error
);
  import dsp_boot_loader_pkg::*;

  state_t      state_q;
  state_t      state_d;
  phase_t      phase_q;
  boot_src_t   src_q;
  mem_width_t  width_q;
  mem_width_t  width_rd;
  logic        captured_q;
  logic        boot_mode_q;
  logic [3:0]  irq_b;
  logic [1:0]  piece_q;
  logic [1:0]  last_piece;
  logic [31:0] word_q;
  logic [31:0] word_asm;
  logic [2:0]  gap_cnt_q;
  logic [23:0] count_q;
  logic        first_block_q;
  logic        rd_done;
  logic        rd_bad_width;
  logic        wr_done;
  logic [5:0]  vec_num;

  boot_ser_if ser ();

  serial_word_rx u_ser_rx
  (
    .i_core_clk           (i_core_clk),
    .i_rst_b              (i_rst_b),
    .i_ser_bit_clk        (i_ser_bit_clk),
    .i_receive_frame_sync (i_receive_frame_sync),
    .i_ser_data           (i_ser_data),
    .ser                  (ser.rx)
  );

  // ----------------------------------------
  // strap capture
  // ----------------------------------------
  // caught on the first edge after release, never under reset
  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      captured_q  <= 1'b0;
      boot_mode_q <= 1'b0;
    end
    else if (!captured_q)
    begin
      captured_q  <= 1'b1;
      boot_mode_q <= i_boot_mode_strap_pin;
    end
  end

  assign o_boot_loader_mode = boot_mode_q;
  assign irq_b = {i_ext_irq_pin_3_b, i_ext_irq_pin_2_b, i_ext_irq_pin_1_b, i_ext_irq_pin_0_b};

  // ----------------------------------------
  // read assembly
  // ----------------------------------------
  // width of the very first piece comes from its own low byte
  always_comb
  begin
    width_rd     = width_q;
    rd_bad_width = 1'b0;
    if (phase_q == PH_WIDTH && piece_q == 2'h0)
    begin
      case (i_mem_rd_data[7:0])
        `BL_WIDTH_8:  width_rd = MW_8;
        `BL_WIDTH_16: width_rd = MW_16;
        `BL_WIDTH_32: width_rd = MW_32;
        default:      rd_bad_width = 1'b1;
      endcase
    end
    case (width_rd)
      MW_8:    last_piece = 2'h3;
      MW_16:   last_piece = 2'h1;
      default: last_piece = 2'h0;
    endcase
    word_asm = word_q;
    case (width_rd)
      MW_8:    word_asm[8*piece_q +: 8] = i_mem_rd_data[7:0];
      MW_16:   word_asm[16*piece_q[0] +: 16] = i_mem_rd_data[15:0];
      default: word_asm = i_mem_rd_data;
    endcase
  end

  assign rd_done    = (state_q == S_READ) && i_mem_rd_ack;
  assign wr_done    = (state_q == S_WRITE) && i_wr_ack;

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      S_OFF:
        if (captured_q && boot_mode_q)
          state_d = S_POLL;
      S_POLL:
        if (!irq_b[0] || !irq_b[1] || !irq_b[2])
          state_d = S_GAP;
        else if (!irq_b[3])
          state_d = S_SER;
      S_GAP:
        if (gap_cnt_q == 3'h0)
          state_d = S_READ;
      S_READ:
        if (rd_done && rd_bad_width)
          state_d = S_ERR;
        else if (rd_done && piece_q == last_piece)
          state_d = S_WORD;
        else if (rd_done)
          state_d = S_GAP;
      S_SER:
        if (ser.valid)
          state_d = S_WORD;
      S_WORD:
        case (phase_q)
          PH_LEN:
            if (word_q == 32'h0000_0000)
              state_d = first_block_q ? S_ERR : S_RUN;
            else if (word_q[31:`BL_LEN_W] != 8'h00)
              state_d = S_ERR;
            else
              state_d = (src_q == SRC_SERIAL) ? S_SER : S_GAP;
          PH_CODE:
            state_d = S_WRITE;
          default:
            state_d = (src_q == SRC_SERIAL) ? S_SER : S_GAP;
        endcase
      S_WRITE:
        if (wr_done)
          state_d = (src_q == SRC_SERIAL) ? S_SER : S_GAP;
      S_RUN:
        state_d = S_RUN;
      S_ERR:
        state_d = S_ERR;
      default:
        state_d = S_ERR;
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      state_q <= S_OFF;
    else
      state_q <= state_d;
  end

  // ----------------------------------------
  // source and header phase
  // ----------------------------------------
  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      src_q   <= SRC_BOOT1;
      phase_q <= PH_WIDTH;
    end
    else if (state_q == S_POLL)
    begin
      if (!irq_b[0])
        src_q <= SRC_BOOT1;
      else if (!irq_b[1])
        src_q <= SRC_BOOT2;
      else if (!irq_b[2])
        src_q <= SRC_BOOT3;
      else
        src_q <= SRC_SERIAL;
      phase_q <= (irq_b[2:0] == 3'h7) ? PH_LEN : PH_WIDTH;
    end
    else if (state_q == S_WORD)
    begin
      case (phase_q)
        PH_WIDTH:  phase_q <= PH_BUSCFG;
        PH_BUSCFG: phase_q <= PH_LEN;
        PH_LEN:    phase_q <= PH_DEST;
        PH_DEST:   phase_q <= PH_CODE;
        default:   phase_q <= PH_CODE;
      endcase
    end
    else if (wr_done && count_q == 24'h00_0001)
      phase_q <= PH_LEN;
  end

  // ----------------------------------------
  // boot memory access
  // ----------------------------------------
  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_mem_addr <= 24'h00_0000;
      piece_q    <= 2'h0;
      word_q     <= 32'h0000_0000;
      width_q    <= MW_32;
    end
    else if (state_q == S_POLL)
    begin
      piece_q <= 2'h0;
      if (!irq_b[0])
        o_mem_addr <= `BL_BOOT1_ADDR;
      else if (!irq_b[1])
        o_mem_addr <= `BL_BOOT2_ADDR;
      else if (!irq_b[2])
        o_mem_addr <= `BL_BOOT3_ADDR;
    end
    else if (rd_done)
    begin
      o_mem_addr <= o_mem_addr + 24'h00_0001;
      word_q     <= word_asm;
      width_q    <= width_rd;
      piece_q    <= (piece_q == last_piece) ? 2'h0 : piece_q + 2'h1;
    end
    else if (state_q == S_SER && ser.valid)
      word_q <= ser.word;
  end

  assign o_mem_rd_req = (state_q == S_READ);

  // wait states from the bus control word, before every boot memory read
  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      gap_cnt_q <= 3'h0;
    else if (state_q != S_GAP && state_d == S_GAP)
      gap_cnt_q <= o_bus_ctrl[`BL_WCNT_LSB +: `BL_WCNT_W];
    else if (state_q == S_GAP && gap_cnt_q != 3'h0)
      gap_cnt_q <= gap_cnt_q - 3'h1;
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      o_bus_ctrl <= `BL_BUS_CTRL_RST;
    else if (state_q == S_WORD && phase_q == PH_BUSCFG)
      o_bus_ctrl <= word_q;
  end

  // ----------------------------------------
  // block copy
  // ----------------------------------------
  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      count_q       <= 24'h00_0000;
      o_wr_addr     <= 24'h00_0000;
      o_wr_data     <= 32'h0000_0000;
      first_block_q <= 1'b1;
      o_exec_addr   <= 24'h00_0000;
    end
    else if (state_q == S_WORD)
    begin
      case (phase_q)
        PH_LEN:
          count_q <= word_q[`BL_LEN_W-1:0];
        PH_DEST:
        begin
          o_wr_addr <= word_q[`BL_ADDR_W-1:0];
          if (first_block_q)
            o_exec_addr <= word_q[`BL_ADDR_W-1:0];
          first_block_q <= 1'b0;
        end
        PH_CODE:
          o_wr_data <= word_q;
        default:
          count_q <= count_q;
      endcase
    end
    else if (wr_done)
    begin
      o_wr_addr <= o_wr_addr + 24'h00_0001;
      count_q   <= count_q - 24'h00_0001;
    end
  end

  assign o_wr_req           = (state_q == S_WRITE);
  assign o_exec_start       = (state_q == S_WORD) && (state_d == S_RUN);
  assign o_boot_error       = (state_q == S_ERR);
  assign o_ser_fixed32_lock = boot_mode_q && (src_q == SRC_SERIAL) && (state_q != S_OFF)
                              && (state_q != S_POLL);
  assign ser.enable         = o_ser_fixed32_lock && (state_q != S_RUN);

  // ----------------------------------------
  // branch slot lookup
  // ----------------------------------------
  always_comb
  begin
    case (i_vec_src)
      VEC_EXT_IRQ_PIN_0:  vec_num = `BL_VEC_EXT_IRQ_PIN_0;
      VEC_EXT_IRQ_PIN_1:  vec_num = `BL_VEC_EXT_IRQ_PIN_0 + 6'h01;
      VEC_EXT_IRQ_PIN_2:  vec_num = `BL_VEC_EXT_IRQ_PIN_0 + 6'h02;
      VEC_EXT_IRQ_PIN_3:  vec_num = `BL_VEC_EXT_IRQ_PIN_0 + 6'h03;
      VEC_XMIT:  vec_num = `BL_VEC_XMIT;
      VEC_RECV:  vec_num = `BL_VEC_RECV;
      VEC_TIM_A: vec_num = `BL_VEC_TIM_A;
      VEC_TIM_B: vec_num = `BL_VEC_TIM_B;
      VEC_DMA:   vec_num = `BL_VEC_DMA;
      default:   vec_num = `BL_VEC_FIRST_TRAP_SLOT + {1'b0, (i_vec_trap_num > `BL_TRAP_LAST)
                                            ? `BL_TRAP_LAST : i_vec_trap_num};
    endcase
  end

  // loader mode branches through ram slots; otherwise direct vector number
  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      o_vec_addr <= 24'h00_0000;
    else if (boot_mode_q)
      o_vec_addr <= `BL_VEC_BASE + {18'h0_0000, vec_num};
    else
      o_vec_addr <= {18'h0_0000, vec_num};
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  AST_NO_LOAD_WITHOUT_STRAP:
  assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    (captured_q && !boot_mode_q) |-> (state_q == S_OFF) && !o_mem_rd_req && !o_wr_req)
  else $error("loader active with strap low");

  AST_PIN0_WINS:
  assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    (state_q == S_POLL && !i_ext_irq_pin_0_b)
    |=> (src_q == SRC_BOOT1) && (o_mem_addr == `BL_BOOT1_ADDR) && (state_q == S_GAP))
  else $error("pin 0 did not select first region");

  AST_PIN2_REGION:
  assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    (state_q == S_POLL && irq_b[1:0] == 2'h3 && !irq_b[2]) |=> o_mem_addr == `BL_BOOT3_ADDR)
  else $error("pin 2 did not select third region");

  AST_SERIAL_SKIPS_CFG:
  assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    (state_q == S_POLL && irq_b == 4'h7) |=> (state_q == S_SER) && (phase_q == PH_LEN))
  else $error("serial load did not start at length word");

  AST_BYTE_NEEDS_FOUR:
  assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    (rd_done && width_q == MW_8 && phase_q != PH_WIDTH && piece_q != 2'h3)
    |=> state_q == S_GAP)
  else $error("byte memory word finished early");

  AST_WAIT_STATES:
  assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    (state_q == S_GAP && $past(state_q) != S_GAP && gap_cnt_q == 3'h2)
    |-> (state_q == S_GAP) [*3] ##1 (state_q == S_READ))
  else $error("wait states not honoured");

  AST_WRITE_STEP:
  assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    wr_done |=> o_wr_addr == $past(o_wr_addr) + 24'h00_0001)
  else $error("destination did not advance by one");

  AST_BLOCK_END:
  assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    (wr_done && count_q == 24'h00_0001) |=> phase_q == PH_LEN)
  else $error("block did not end after its length");

  AST_ZERO_ENDS:
  assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    (state_q == S_WORD && phase_q == PH_LEN && word_q == 32'h0 && !first_block_q)
    |-> o_exec_start ##1 (state_q == S_RUN) && !o_wr_req)
  else $error("zero length did not start execution");

  AST_EXEC_FIRST:
  assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    (state_q == S_WORD && phase_q == PH_DEST && !first_block_q) |=> $stable(o_exec_addr))
  else $error("execution address moved after first block");

  AST_VEC_WINDOW:
  assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    boot_mode_q |=> (o_vec_addr > `BL_VEC_BASE) && (o_vec_addr <= `BL_VEC_BASE + 24'h3F))
  else $error("branch slot outside last 63 words");
endmodule : dsp_boot_loader

//--- rtl/dsp_boot_loader_map.svh
`ifndef DSP_BOOT_LOADER_MAP_SVH
`define DSP_BOOT_LOADER_MAP_SVH

// ----------------------------------------
// boot source base addresses
// ----------------------------------------
`define BL_BOOT1_ADDR     24'h001000
`define BL_BOOT2_ADDR     24'h400000
`define BL_BOOT3_ADDR     24'hFFF000

// ----------------------------------------
// header word 0: memory width codes
// ----------------------------------------
`define BL_WIDTH_8        8'h08
`define BL_WIDTH_16       8'h10
`define BL_WIDTH_32       8'h20

// ----------------------------------------
// header word 1: bus control fields
// ----------------------------------------
`define BL_WCNT_LSB       5
`define BL_WCNT_W         3
`define BL_BUS_CTRL_RST   32'h0000_0000

// ----------------------------------------
// header words 2 and 3: block length limit and destination width
// ----------------------------------------
`define BL_LEN_W          24
`define BL_ADDR_W         24

// ----------------------------------------
// serial port word
// ----------------------------------------
`define BL_SER_WORD_BITS  32

// ----------------------------------------
// branch slot table
// ----------------------------------------
`define BL_VEC_BASE       24'h809FC0
`define BL_VEC_EXT_IRQ_PIN_0       6'h01
`define BL_VEC_XMIT       6'h05
`define BL_VEC_RECV       6'h06
`define BL_VEC_TIM_A      6'h09
`define BL_VEC_TIM_B      6'h0A
`define BL_VEC_DMA        6'h0B
`define BL_VEC_FIRST_TRAP_SLOT      6'h20
`define BL_TRAP_LAST      5'h1B

`endif

//--- rtl/dsp_boot_loader_pkg.sv
package dsp_boot_loader_pkg;

  typedef enum logic [3:0] {
    S_OFF,
    S_POLL,
    S_GAP,
    S_READ,
    S_SER,
    S_WORD,
    S_WRITE,
    S_RUN,
    S_ERR
  } state_t;

  typedef enum logic [2:0] {
    PH_WIDTH,
    PH_BUSCFG,
    PH_LEN,
    PH_DEST,
    PH_CODE
  } phase_t;

  typedef enum logic [1:0] {
    SRC_BOOT1,
    SRC_BOOT2,
    SRC_BOOT3,
    SRC_SERIAL
  } boot_src_t;

  typedef enum logic [1:0] {
    MW_8,
    MW_16,
    MW_32
  } mem_width_t;

  typedef enum logic [3:0] {
    VEC_EXT_IRQ_PIN_0,
    VEC_EXT_IRQ_PIN_1,
    VEC_EXT_IRQ_PIN_2,
    VEC_EXT_IRQ_PIN_3,
    VEC_XMIT,
    VEC_RECV,
    VEC_TIM_A,
    VEC_TIM_B,
    VEC_DMA,
    VEC_TRAP
  } vec_src_t;

endpackage : dsp_boot_loader_pkg

//--- rtl/serial_word_rx.sv
`timescale 1ns/1ps
`include "dsp_boot_loader_map.svh"
module serial_word_rx
(
  // clock and reset
  input  wire logic i_core_clk,
  input  wire logic i_rst_b,
  // serial pins
  input  wire logic i_ser_bit_clk,
  input  wire logic i_receive_frame_sync,
  input  wire logic i_ser_data,
  // to loader core
  boot_ser_if.rx    ser
);
  logic        clk_prev_q;
  logic        busy_q;
  logic [5:0]  bit_cnt_q;
  logic [31:0] shift_q;
  logic        rise;

  assign rise = i_ser_bit_clk & ~clk_prev_q;

  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      clk_prev_q <= 1'b0;
    else
      clk_prev_q <= i_ser_bit_clk;
  end

  // ----------------------------------------
  // fixed 32-bit burst, msb first
  // ----------------------------------------
  always_ff @(posedge i_core_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      busy_q    <= 1'b0;
      bit_cnt_q <= 6'h00;
      shift_q   <= 32'h0000_0000;
      ser.valid <= 1'b0;
      ser.word  <= 32'h0000_0000;
    end
    else
    begin
      ser.valid <= 1'b0;
      if (!ser.enable)
        busy_q <= 1'b0;
      else if (rise && !busy_q && i_receive_frame_sync)
      begin
        busy_q    <= 1'b1;
        bit_cnt_q <= 6'h00;
      end
      else if (rise && busy_q)
      begin
        shift_q   <= {shift_q[30:0], i_ser_data};
        bit_cnt_q <= bit_cnt_q + 6'h01;
        if (bit_cnt_q == 6'(`BL_SER_WORD_BITS - 1))
        begin
          busy_q    <= 1'b0;
          ser.valid <= 1'b1;
          ser.word  <= {shift_q[30:0], i_ser_data};
        end
      end
    end
  end

  AST_SER_VALID_PULSE:
  assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    ser.valid |=> !ser.valid)
  else $error("serial word valid held longer than one cycle");

  AST_SER_NEEDS_32:
  assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
    ser.valid |-> $past(busy_q) && $past(bit_cnt_q) == 6'h1F)
  else $error("serial word completed before 32 bits");
endmodule : serial_word_rx

//--- sim/boot_mem_model.sv
`timescale 1ns/1ps
module boot_mem_model
(
  // clock
  input  wire logic        i_core_clk,
  // boot memory side
  input  wire logic        i_mem_rd_req,
  input  wire logic [23:0] i_mem_addr,
  output logic [31:0]      o_mem_rd_data,
  output logic             o_mem_rd_ack,
  // destination side
  input  wire logic        i_wr_req,
  input  wire logic [23:0] i_wr_addr,
  input  wire logic [31:0] i_wr_data,
  output logic             o_wr_ack
);
  logic [31:0] mem [int];
  logic [55:0] wlog [$];
  int          wait_n;

  initial
  begin
    o_mem_rd_data = 32'h0;
    o_mem_rd_ack = 1'b0;
    o_wr_ack = 1'b0;
    wait_n = 0;
  end

  // -------------------------------
  // answers, then idle 0 to 3 cycles after a read (low address bits), 1 after a write
  // -------------------------------
  always @(negedge i_core_clk)
  begin
    o_mem_rd_ack <= 1'b0;
    o_wr_ack <= 1'b0;
    // released data bus never shows the last value
    o_mem_rd_data <= ~o_mem_rd_data;
    if (wait_n > 0)
      wait_n <= wait_n - 1;
    else if (i_mem_rd_req && !o_mem_rd_ack)
    begin
      o_mem_rd_data <= mem.exists(int'(i_mem_addr)) ? mem[int'(i_mem_addr)] : 32'h0;
      o_mem_rd_ack <= 1'b1;
      wait_n <= int'(i_mem_addr[1:0]);
    end
    else if (i_wr_req && !o_wr_ack)
    begin
      wlog.push_back({i_wr_addr, i_wr_data});
      o_wr_ack <= 1'b1;
      wait_n <= 1;
    end
  end
endmodule : boot_mem_model

//--- sim/dsp_boot_loader_bench.sv
`timescale 1ns/1ps
module dsp_boot_loader_bench;
  import dsp_boot_loader_pkg::*;
  logic        clk, rst_b, strap, sck, fs, sd, rd_req, rd_ack, wr_req, wr_ack;
  logic        lock, mode, go, err;
  logic [3:0]  irq_b;
  logic [23:0] rd_addr, wr_addr, vaddr, xaddr;
  logic [31:0] rd_data, wr_data, bus_ctrl;
  vec_src_t    vsrc;
  logic [4:0]  trap;
  logic [15:0] seed;
  int          n_fail, tests_run;

  dsp_boot_loader DUT
  (
    .i_core_clk(clk), .i_rst_b(rst_b), .i_boot_mode_strap_pin(strap),
    .i_ext_irq_pin_0_b(irq_b[0]), .i_ext_irq_pin_1_b(irq_b[1]),
    .i_ext_irq_pin_2_b(irq_b[2]), .i_ext_irq_pin_3_b(irq_b[3]),
    .o_mem_rd_req(rd_req), .o_mem_addr(rd_addr), .i_mem_rd_data(rd_data),
    .i_mem_rd_ack(rd_ack), .o_bus_ctrl(bus_ctrl), .o_wr_req(wr_req),
    .o_wr_addr(wr_addr), .o_wr_data(wr_data), .i_wr_ack(wr_ack),
    .i_ser_bit_clk(sck), .i_receive_frame_sync(fs), .i_ser_data(sd),
    .o_ser_fixed32_lock(lock), .i_vec_src(vsrc), .i_vec_trap_num(trap),
    .o_vec_addr(vaddr), .o_boot_loader_mode(mode), .o_exec_start(go),
    .o_exec_addr(xaddr), .o_boot_error(err)
  );

  boot_mem_model p
  (
    .i_core_clk(clk), .i_mem_rd_req(rd_req), .i_mem_addr(rd_addr),
    .o_mem_rd_data(rd_data), .o_mem_rd_ack(rd_ack), .i_wr_req(wr_req),
    .i_wr_addr(wr_addr), .i_wr_data(wr_data), .o_wr_ack(wr_ack)
  );

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr

  task automatic check(input logic [55:0] seen, input logic [55:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  task automatic complete_run;
    $display("checks %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : complete_run

  task automatic rst(input logic s);
    @(negedge clk);
    rst_b = 1'b0;
    strap = s;
    irq_b = 4'hF;
    p.mem.delete();
    p.wlog.delete();
    repeat (20) @(negedge clk);
    rst_b = 1'b1;
    // late source select must still be honoured
    repeat (4) @(negedge clk);
  endtask : rst

  // one bit-clock period, clock left low between frames
  task automatic sbit(input logic f, input logic d);
    @(negedge clk);
    sck = 1'b0;
    fs = f;
    sd = d;
    repeat (2) @(negedge clk);
    sck = 1'b1;
    @(negedge clk);
  endtask : sbit

  task automatic sword(input logic [31:0] w);
    sbit(1'b1, ~w[31]);
    for (int i = 31; i >= 0; i--)
      sbit(1'b0, w[i]);
    @(negedge clk);
    sck = 1'b0;
    sd = ~sd;
  endtask : sword

  task automatic vec_check;
    int vn [10] = '{1, 2, 3, 4, 5, 6, 9, 10, 11, 59};
    for (int i = 0; i < 10; i++)
    begin
      @(negedge clk);
      vsrc = vec_src_t'(i);
      seed = lfsr(seed);
      trap = seed[4:0];
      repeat (2) @(negedge clk);
      check(vaddr, (mode ? 24'h809FC0 : 24'h0)
            + 24'((i == 9) ? ((trap > 5'h1B) ? 59 : 32 + int'(trap)) : vn[i]));
    end
  endtask : vec_check

  task automatic load(input int pin, input int wd);
    logic [31:0] w [$];
    logic [55:0] eq [$];
    logic [31:0] c;
    int          a, n;
    int          base [3] = '{32'h1000, 32'h400000, 32'hFFF000};
    rst(1'b1);
    if (pin < 3)
    begin
      w.push_back(32'(wd));
      w.push_back(32'h1058);
    end
    for (int b = 0; b < 2; b++)
    begin
      w.push_back(b ? 32'h1 : 32'h3);
      w.push_back(b ? 32'h100 : 32'h809800);
      for (int k = 0; k < (b ? 1 : 3); k++)
      begin
        seed = lfsr(seed);
        c = {seed, ~seed};
        w.push_back(c);
        eq.push_back({(b ? 24'h100 : 24'h809800) + 24'(k), c});
      end
    end
    w.push_back(32'h0);
    a = (pin < 3) ? base[pin] : 0;
    foreach (w[i])
      for (int k = 0; k < 32 / wd && pin < 3; k++)
        p.mem[a++] = (w[i] >> (k * wd)) & 32'((64'h1 << wd) - 1);
    irq_b[pin] = 1'b0;
    if (pin == 0)
      irq_b[2] = 1'b0;
    if (pin == 3)
      foreach (w[i])
      begin
        sword(w[i]);
        check(lock, 1'b1);
      end
    n = 0;
    while (go !== 1'b1 && n < 30000)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n >= 30000)
    begin
      n_fail++;
      complete_run();
    end
    check(xaddr, 24'h809800);
    check(err, 1'b0);
    check(mode, 1'b1);
    if (pin < 3)
      check(bus_ctrl, 32'h1058);
    check(p.wlog.size(), eq.size());
    foreach (eq[i])
      check(p.wlog[i], eq[i]);
    $display("load test pin %0d width %0d done", pin, wd);
  endtask : load

  initial
  begin
    n_fail = 0;
    tests_run = 0;
    seed = 16'hD975;
    rst_b = 1'b0;
    strap = 1'b0;
    irq_b = 4'hF;
    sck = 1'b0;
    fs = 1'b0;
    sd = 1'b0;
    vsrc = VEC_EXT_IRQ_PIN_0;
    trap = 5'h0;
    load(0, 8);
    load(1, 16);
    load(2, 32);
    vec_check();
    load(3, 32);
    rst(1'b1);
    p.mem[32'h1000] = 32'h7;
    irq_b[0] = 1'b0;
    repeat (60) @(negedge clk);
    check(err, 1'b1);
    check(go, 1'b0);
    $display("bad width test done");
    rst(1'b1);
    p.mem[32'h1000] = 32'h20;
    p.mem[32'h1001] = 32'h0;
    p.mem[32'h1002] = 32'h0;
    irq_b[0] = 1'b0;
    repeat (60) @(negedge clk);
    check(err, 1'b1);
    check(p.wlog.size(), 0);
    $display("empty first block test done");
    rst(1'b0);
    irq_b[0] = 1'b0;
    repeat (40) @(negedge clk);
    check(mode, 1'b0);
    check(rd_req, 1'b0);
    vec_check();
    $display("processor mode test done");
    complete_run();
  end
endmodule : dsp_boot_loader_bench
